// [rtl/knock_pkg.sv]
// Shared constants, register map and carrier types of the knock package controller
package knock_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int CYL_N       = 12;
  localparam int OUT_N       = 4;
  localparam int SEQ_LEN     = 16;
  localparam int SEQ_W       = CYL_N + 1;   // Bit 12 is the common table
  localparam int SEQ_COMMON  = CYL_N;
  localparam int DECIDE_LAST = CYL_N - 1;

  // ---------------------------------------------------------------
  // Value ranges
  // ---------------------------------------------------------------
  localparam logic [11:0] ANGLE_FULL = 12'h2d0;   // 720 crank degrees
  localparam logic [15:0] UNIT_FULL  = 16'h2710;  // 10000 stands for 1.0
  localparam logic [27:0] PROB_SCALE = 28'h0002710;
  localparam logic [15:0] LFSR_SEED  = 16'hace1;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_GLOBAL  = 12'h000;
  localparam logic [11:0] OFS_LEVELS  = 12'h004;
  localparam logic [11:0] OFS_ROUTE01 = 12'h008;
  localparam logic [11:0] OFS_ROUTE23 = 12'h00c;
  localparam logic [11:0] OFS_STATUS  = 12'h010;
  localparam logic [5:0]  BLK_CFG     = 6'h01;    // 0x040..0x06c
  localparam logic [5:0]  BLK_AMP     = 6'h02;    // 0x080..0x0ac
  localparam logic [5:0]  BLK_SEQ0    = 6'h04;    // 0x100..0x13c

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GL_TRIG_MODE = 10;
  localparam int GL_TRIG      = 11;
  localparam int CF_SHIFT     = 10;
  localparam int CF_MODE      = 18;
  localparam int CF_STYPE     = 19;
  localparam int CF_GATE      = 20;
  localparam int ST_STEP      = 12;
  localparam int ST_PLAY      = 16;
  localparam int ST_BUSY      = 17;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] GATE_RST = 12'hfff;     // Knocking blocked
  localparam logic [9:0]  ANG_RST  = 10'h000;
  localparam logic [15:0] LVL_RST  = 16'h0000;

  // Packets towards the analogue synthesis
  typedef struct packed {
    logic [OUT_N-1:0]       fire;
    logic [OUT_N-1:0][15:0] level;
  } pkg_out_t;

  // Whole state of the controller apart from the sequence table memory in seq_mem
  typedef struct packed {
    logic [9:0]             ref_phase;
    logic                   trig_mode;
    logic                   trig_sw;
    logic [15:0]            quiet;
    logic [15:0]            spread;
    logic [OUT_N-1:0][11:0] route;
    logic [CYL_N-1:0][9:0]  base;
    logic [CYL_N-1:0][7:0]  shift;
    logic [CYL_N-1:0]       mode;
    logic [CYL_N-1:0]       stype;
    logic [CYL_N-1:0]       gate;
    logic [CYL_N-1:0][15:0] likely;
    logic [CYL_N-1:0][15:0] loud;
    logic [9:0]             prev_angle;
    logic                   prev_trig;
    logic                   playing;
    logic [3:0]             step;
    logic                   busy;
    logic [3:0]             idx;
    logic [CYL_N-1:0]       knock;
    logic [15:0]            lfsr;
    logic                   dp_wr;
    logic [11:0]            dp_addr;
    logic [31:0]            rdata;
    logic                   ready;
    pkg_out_t               out;
  } ctrl_state_t;

endpackage

// [rtl/seq_mem.sv]
// Sequence table store: one word per step, common plus individual bits
`timescale 1ns/1ns
module seq_mem (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [3:0]              wr_addr,
  input  wire logic [knock_pkg::SEQ_W-1:0] wr_data,
  input  wire logic [3:0]              rd_addr,
  output logic      [knock_pkg::SEQ_W-1:0] rd_data
);

  logic [knock_pkg::SEQ_W-1:0] mem [knock_pkg::SEQ_LEN];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // No reset: tables are loaded by software before playback
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // seq_mem

// [rtl/knock_ctrl.sv]
// Knock package controller: angle placement, knock decision, levels, AHB-Lite
//
// Functional notes
// R1: Start angle is reference phase plus cylinder base angle plus runtime shift.
// R2: Per-cylinder base angle is configurable from 0 to 720 crank degrees.
// R3: Start shift is signed, -127 to +127, one crank degree per step.
// R4: Per 720 degree cycle, mode 0 uses probability, mode 1 sequence tables.
// R5: Sequence type 0 plays the common table, 1 the cylinder's own.
// R6: Twelve gates; gate 0 lets knocking happen, gate 1 blocks it.
// R7: Likelihood 0..10000 counts only for cylinders in probability mode.
// R8: A 0 to 1 edge on the sequence trigger starts playback.
// R9: A trigger edge during playback restarts it from the first step.
// R10: Random level spread 0..10000 scales amplitude variation, 0 none.
// R11: The spread applies to knocking and non-knocking packages alike.
// R12: Non-knocking cycles emit the shared quiet package level.
// R13: Knocking cycles emit the cylinder's own loud package level.
// R14: Every setting may be rewritten at any time and acts at once.
// R15: Trigger mode 0 replays tables continuously, 1 plays once per trigger.
// R16: A package goes to every output whose mapping entry includes the cylinder; on a collision only the lowest cylinder's package takes the output.
// R17: Probability mode draws a fresh random number per cylinder per cycle.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module knock_ctrl (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [9:0]          crank_angle,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  output knock_pkg::pkg_out_t      pkg_out
);

  knock_pkg::ctrl_state_t st;
  knock_pkg::ctrl_state_t next_st;

  logic [knock_pkg::SEQ_W-1:0]  seq_word;
  logic                         seq_we;
  logic [knock_pkg::CYL_N-1:0]  hit;
  logic                         wrap;
  logic                         trig_rise;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Folds the three angle terms into 0..719; four passes cover two 10-bit terms
  function automatic logic [9:0] wrap_angle(input logic [9:0] r, input logic [9:0] b,
                                            input logic [7:0] s);
    logic [11:0] sum;
    sum = 12'({2'b00, r}) + 12'({2'b00, b}) + 12'({{4{s[7]}}, s}) + knock_pkg::ANGLE_FULL;
    for (int k = 0; k < 4; k++) begin
      if (sum >= knock_pkg::ANGLE_FULL) begin
        sum = sum - knock_pkg::ANGLE_FULL;
      end
    end
    return sum[9:0];
  endfunction

  // Adds signed noise of up to +-spread and clamps to 0..10000
  function automatic logic [15:0] vary(input logic [15:0] lvl, input logic [15:0] spr,
                                       input logic [15:0] rnd);
    logic signed [32:0] prod;
    logic signed [18:0] sum;
    prod = $signed(rnd) * $signed({1'b0, spr});
    sum  = $signed({3'b000, lvl}) + $signed({prod[32], prod[32:15]});
    if (sum < 0) begin
      return 16'h0000;
    end else if (sum > $signed({3'b000, knock_pkg::UNIT_FULL})) begin
      return knock_pkg::UNIT_FULL;
    end
    return sum[15:0];
  endfunction

  // Cylinder slot of a per-cylinder register block, or none
  function automatic logic slot_ok(input logic [11:0] a, input logic [5:0] blk);
    return (a[11:6] == blk) && (a[5:2] < 4'(knock_pkg::CYL_N));
  endfunction

  // ---------------------------------------------------------------
  // Sequence table memory
  // ---------------------------------------------------------------
  assign seq_we = st.dp_wr && (st.dp_addr[11:6] == knock_pkg::BLK_SEQ0);

  seq_mem u_seq_mem (
    .clk     (clk),
    .wr_en   (seq_we),
    .wr_addr (st.dp_addr[5:2]),
    .wr_data (hwdata[knock_pkg::SEQ_W-1:0]),
    .rd_addr (st.step),
    .rd_data (seq_word)
  );

  // ---------------------------------------------------------------
  // Angle tracking
  // ---------------------------------------------------------------
  // A crank step is a change of angle; one going backwards starts a new cycle
  assign wrap      = crank_angle < st.prev_angle;
  assign trig_rise = st.trig_sw && !st.prev_trig; // R8

  always_comb begin
    for (int c = 0; c < knock_pkg::CYL_N; c++) begin
      // R1 R2 R3
      hit[c] = (crank_angle != st.prev_angle) &&
               (crank_angle == wrap_angle(st.ref_phase, st.base[c], st.shift[c]));
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [27:0] scaled;
    logic [3:0]  i;
    logic        kn;
    logic [15:0] lvl;
    scaled  = 28'h0000000;
    i       = 4'h0;
    kn      = 1'b0;
    lvl     = 16'h0000;
    next_st = st;

    // Free-running noise source
    next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
    next_st.prev_angle = crank_angle;
    next_st.prev_trig  = st.trig_sw;

    // Sequential decision walks one cylinder a clock after the cycle starts
    if (st.busy) begin
      i      = st.idx;
      scaled = {14'h0000, st.lfsr[13:0]} * knock_pkg::PROB_SCALE;
      if (!st.mode[i]) begin
        kn = {2'b00, scaled[27:14]} < st.likely[i]; // R4 R7 R17
      end else if (st.playing) begin
        kn = st.stype[i] ? seq_word[i] : seq_word[knock_pkg::SEQ_COMMON]; // R4 R5
      end
      next_st.knock[i] = kn && !st.gate[i]; // R6
      if (st.idx == 4'(knock_pkg::DECIDE_LAST)) begin
        next_st.busy = 1'b0;
        // Playback moves one step per engine cycle
        if (st.playing) begin
          if (st.step == 4'(knock_pkg::SEQ_LEN - 1)) begin
            next_st.step    = 4'h0;
            next_st.playing = !st.trig_mode; // R15
          end else begin
            next_st.step = st.step + 4'h1;
          end
        end
      end else begin
        next_st.idx = st.idx + 4'h1;
      end
    end
    if (wrap) begin
      next_st.busy = 1'b1;
      next_st.idx  = 4'h0;
    end

    // Trigger edge starts or restarts playback, winning over stepping
    if (trig_rise) begin
      next_st.playing = 1'b1; // R8 R9
      next_st.step    = 4'h0; // R9
    end

    // Package emission; lowest cylinder wins an output on a collision
    next_st.out.fire = '0;
    for (int o = 0; o < knock_pkg::OUT_N; o++) begin
      for (int c = knock_pkg::CYL_N - 1; c >= 0; c--) begin
        if (hit[c] && st.route[o][c]) begin // R16
          lvl = st.knock[c] ? st.loud[c] : st.quiet; // R12 R13
          next_st.out.fire[o]  = 1'b1;
          next_st.out.level[o] = vary(lvl, st.spread, st.lfsr); // R10 R11
        end
      end
    end

    // AHB-Lite address phase; zero wait states, always OKAY
    next_st.ready = 1'b1;
    next_st.dp_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_st.dp_wr   = hwrite;
      next_st.dp_addr = haddr[11:0];
      next_st.rdata   = 32'h00000000;
      if (!hwrite) begin
        if (haddr[11:0] == knock_pkg::OFS_GLOBAL) begin
          next_st.rdata[9:0] = st.ref_phase;
          next_st.rdata[knock_pkg::GL_TRIG_MODE] = st.trig_mode;
          next_st.rdata[knock_pkg::GL_TRIG]      = st.trig_sw;
        end else if (haddr[11:0] == knock_pkg::OFS_LEVELS) begin
          next_st.rdata = {st.spread, st.quiet};
        end else if (haddr[11:0] == knock_pkg::OFS_ROUTE01) begin
          next_st.rdata[23:0] = {st.route[1], st.route[0]};
        end else if (haddr[11:0] == knock_pkg::OFS_ROUTE23) begin
          next_st.rdata[23:0] = {st.route[3], st.route[2]};
        end else if (haddr[11:0] == knock_pkg::OFS_STATUS) begin
          next_st.rdata[11:0] = st.knock;
          next_st.rdata[knock_pkg::ST_STEP +: 4] = st.step;
          next_st.rdata[knock_pkg::ST_PLAY] = st.playing;
          next_st.rdata[knock_pkg::ST_BUSY] = st.busy;
        end else if (slot_ok(haddr[11:0], knock_pkg::BLK_CFG)) begin
          i = haddr[5:2];
          next_st.rdata[9:0] = st.base[i];
          next_st.rdata[17:10] = st.shift[i];
          next_st.rdata[knock_pkg::CF_MODE]  = st.mode[i];
          next_st.rdata[knock_pkg::CF_STYPE] = st.stype[i];
          next_st.rdata[knock_pkg::CF_GATE]  = st.gate[i];
        end else if (slot_ok(haddr[11:0], knock_pkg::BLK_AMP)) begin
          i = haddr[5:2];
          next_st.rdata = {st.loud[i], st.likely[i]};
        end
      end
    end

    // AHB-Lite data phase write; takes effect at once while running
    if (st.dp_wr) begin // R14
      if (st.dp_addr == knock_pkg::OFS_GLOBAL) begin
        next_st.ref_phase = hwdata[9:0];
        next_st.trig_mode = hwdata[knock_pkg::GL_TRIG_MODE];
        next_st.trig_sw   = hwdata[knock_pkg::GL_TRIG];
      end else if (st.dp_addr == knock_pkg::OFS_LEVELS) begin
        next_st.quiet  = hwdata[15:0];
        next_st.spread = hwdata[31:16];
      end else if (st.dp_addr == knock_pkg::OFS_ROUTE01) begin
        next_st.route[0] = hwdata[11:0];
        next_st.route[1] = hwdata[23:12];
      end else if (st.dp_addr == knock_pkg::OFS_ROUTE23) begin
        next_st.route[2] = hwdata[11:0];
        next_st.route[3] = hwdata[23:12];
      end else if (slot_ok(st.dp_addr, knock_pkg::BLK_CFG)) begin
        i = st.dp_addr[5:2];
        next_st.base[i]  = hwdata[9:0];
        next_st.shift[i] = hwdata[17:10];
        next_st.mode[i]  = hwdata[knock_pkg::CF_MODE];
        next_st.stype[i] = hwdata[knock_pkg::CF_STYPE];
        next_st.gate[i]  = hwdata[knock_pkg::CF_GATE];
      end else if (slot_ok(st.dp_addr, knock_pkg::BLK_AMP)) begin
        i = st.dp_addr[5:2];
        next_st.likely[i] = hwdata[15:0];
        next_st.loud[i]   = hwdata[31:16];
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st           <= '0;
      st.gate      <= knock_pkg::GATE_RST;
      st.ref_phase <= knock_pkg::ANG_RST;
      st.quiet     <= knock_pkg::LVL_RST;
      st.lfsr      <= knock_pkg::LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout = st.ready;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;
  assign pkg_out   = st.out;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_decide_run;
    st.busy [*8];
  endsequence

  property p_trig_start;
    trig_rise |=> st.playing && (st.step == 4'h0);
  endproperty
  a_trig_start: assert property (p_trig_start) // R8
    else $error("trigger edge did not start playback");

  property p_retrigger;
    trig_rise && st.playing && (st.step != 4'h0) |=> st.step == 4'h0;
  endproperty
  a_retrigger: assert property (p_retrigger) // R9
    else $error("retrigger did not restart playback");

  property p_cycle_decide;
    wrap && !rst |=> (st.idx == 4'h0) ##0 s_decide_run;
  endproperty
  a_cycle_decide: assert property (p_cycle_decide) // R4
    else $error("cycle start did not run the decision walk");

  property p_gate_block;
    st.busy && st.gate[st.idx] |=> !st.knock[$past(st.idx)];
  endproperty
  a_gate_block: assert property (p_gate_block) // R6
    else $error("gated cylinder marked as knocking");

  property p_seq_common;
    st.busy && st.mode[st.idx] && st.playing && !st.stype[st.idx] && !st.gate[st.idx]
      |=> st.knock[$past(st.idx)] == $past(seq_word[knock_pkg::SEQ_COMMON]);
  endproperty
  a_seq_common: assert property (p_seq_common) // R5
    else $error("common table bit not used");

  property p_single_shot;
    st.busy && (st.idx == 4'(knock_pkg::DECIDE_LAST)) && st.playing && st.trig_mode &&
      (st.step == 4'(knock_pkg::SEQ_LEN - 1)) && !trig_rise |=> !st.playing;
  endproperty
  a_single_shot: assert property (p_single_shot) // R15
    else $error("single shot playback did not stop");

  property p_quiet_level;
    hit[0] && st.route[0][0] && !st.knock[0] && (st.spread == 16'h0000)
      |=> st.out.fire[0] && (st.out.level[0] == $past(st.quiet));
  endproperty
  a_quiet_level: assert property (p_quiet_level) // R12
    else $error("quiet package level wrong");

  property p_loud_level;
    hit[0] && st.route[0][0] && st.knock[0] && (st.spread == 16'h0000)
      |=> st.out.fire[0] && (st.out.level[0] == $past(st.loud[0]));
  endproperty
  a_loud_level: assert property (p_loud_level) // R13
    else $error("loud package level wrong");

  property p_route;
    st.out.fire[1] |-> $past(|(hit & st.route[1]));
  endproperty
  a_route: assert property (p_route) // R16
    else $error("package on unmapped output");

  property p_live_levels;
    st.dp_wr && (st.dp_addr == knock_pkg::OFS_LEVELS)
      |=> (st.quiet == $past(hwdata[15:0])) && (st.spread == $past(hwdata[31:16]));
  endproperty
  a_live_levels: assert property (p_live_levels) // R14
    else $error("level write did not take effect");

endmodule // knock_ctrl

// [testbench/crank_model.sv]
// Engine-side model that turns the crank one degree every few clocks
`timescale 1ns/1ns
module crank_model #(
  parameter int HOLD = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [9:0] crank_angle
);
  int cnt;

  // Each degree is held for HOLD clocks so a one-cycle package lands inside it
  always_ff @(posedge clk) begin
    if (rst) begin
      crank_angle <= 10'h000;
      cnt         <= 0;
    end else if (cnt == HOLD - 1) begin
      cnt <= 0;
      if ({2'b00, crank_angle} == knock_pkg::ANGLE_FULL - 12'h001) begin
        crank_angle <= 10'h000;
      end else begin
        crank_angle <= crank_angle + 10'h001;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // crank_model

// [testbench/tb_top.sv]
// Self-checking bench of the knock package controller
`timescale 1ns/1ns
module tb_top;
  logic                clk;
  logic                rst;
  logic [9:0]          crank_angle;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  knock_pkg::pkg_out_t pkg_out;
  knock_pkg::pkg_out_t seen;
  logic [31:0]         rd;
  int                  error_cnt;
  int                  n_tests;

  // ---------------------------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Two clocks per degree keeps the whole run well inside its cycle budget
  crank_model #(.HOLD(2)) crank_model_i (.clk(clk), .rst(rst), .crank_angle(crank_angle));

  // Single slave, so its own ready is the bus ready
  knock_ctrl knock_ctrl_i (
    .clk(clk), .rst(rst), .crank_angle(crank_angle), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pkg_out(pkg_out)
  );

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Bus master and helpers
  // ---------------------------------------------------------------
  // Bounded wait, a hang counts as a mismatch and closes the run
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk(32'h0, 32'h1, "bus hang");
      tally_and_finish();
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic cfg(input int c, input logic [9:0] base, input logic [7:0] sh,
                     input logic md, input logic st, input logic gt);
    bus_xfer(1'b1, 12'h040 + 12'(4 * c), {11'h000, gt, st, md, sh, base});
  endtask

  task automatic glob(input logic tmode, input logic trig);
    bus_xfer(1'b1, knock_pkg::OFS_GLOBAL, {20'h00000, trig, tmode, 10'h01e});
  endtask

  // Package sampling at the falling edge, where outputs are settled
  task automatic wait_fire(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (pkg_out.fire[0] !== 1'b1 && k < 5000);
      if (k >= 5000) begin
        chk(32'h0, 32'h1, "no package");
        tally_and_finish();
      end
    end
    seen = pkg_out;
  endtask

  task automatic lvl(input logic [15:0] exp);
    chk({16'h0000, seen.level[0]}, {16'h0000, exp}, "package level");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    bus_xfer(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0010_0000, "gate reset");
    bus_xfer(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "okay response");
    cfg(5, 10'h2d0, 8'h81, 1'b1, 1'b1, 1'b0);
    bus_xfer(1'b0, 12'h054, 32'h0);
    chk(rd, 32'h000e_06d0, "cfg readback");
  endtask

  // Start at 30 + 700 - 5 = 5 degrees, then 30 + 700 + 127 wraps to 137
  task automatic t_angle();
    glob(1'b0, 1'b0);
    bus_xfer(1'b1, knock_pkg::OFS_LEVELS, 32'h0000_0bb8);
    bus_xfer(1'b1, knock_pkg::OFS_ROUTE01, 32'h0000_0001);
    bus_xfer(1'b1, knock_pkg::OFS_ROUTE23, 32'h0000_0001);
    cfg(0, 10'h2bc, 8'hfb, 1'b0, 1'b0, 1'b1);
    wait_fire(2);
    chk({22'h0, crank_angle}, 32'h0000_0005, "start angle");
    chk({28'h0, seen.fire}, 32'h0000_0005, "routing");
    lvl(16'h0bb8);
    chk({16'h0000, seen.level[2]}, 32'h0000_0bb8, "second output level");
    cfg(0, 10'h2bc, 8'h7f, 1'b0, 1'b0, 1'b1);
    wait_fire(2);
    chk({22'h0, crank_angle}, 32'h0000_0089, "shifted angle");
  endtask

  task automatic t_prob();
    cfg(0, 10'h2bc, 8'hfb, 1'b0, 1'b0, 1'b0);
    bus_xfer(1'b1, 12'h080, 32'h2328_2710);
    wait_fire(2);
    lvl(16'h2328);
    bus_xfer(1'b1, 12'h080, 32'h2328_0000);
    wait_fire(2);
    lvl(16'h0bb8);
    bus_xfer(1'b1, 12'h080, 32'h2328_2710);
    cfg(0, 10'h2bc, 8'hfb, 1'b0, 1'b0, 1'b1);
    wait_fire(2);
    lvl(16'h0bb8);
    cfg(0, 10'h2bc, 8'hfb, 1'b1, 1'b0, 1'b0);
    wait_fire(2);
    lvl(16'h0bb8);
  endtask

  // Single shot on the common table, with a restart in mid-playback
  task automatic t_seq();
    for (int s = 0; s < knock_pkg::SEQ_LEN; s++) begin
      bus_xfer(1'b1, 12'h100 + 12'(4 * s), 32'h0000_1000);
    end
    glob(1'b1, 1'b1);
    wait_fire(2);
    lvl(16'h2328);
    cfg(0, 10'h2bc, 8'hfb, 1'b1, 1'b1, 1'b0);
    wait_fire(2);
    lvl(16'h0bb8);
    cfg(0, 10'h2bc, 8'hfb, 1'b1, 1'b0, 1'b0);
    wait_fire(4);
    lvl(16'h2328);
    glob(1'b1, 1'b0);
    glob(1'b1, 1'b1);
    wait_fire(12);
    lvl(16'h2328);
    wait_fire(6);
    lvl(16'h0bb8);
  endtask

  // A spread of 1000 keeps the level within 1000 of its base, knocking or not
  task automatic t_noise();
    int moved;
    moved = 0;
    cfg(0, 10'h2bc, 8'hfb, 1'b0, 1'b0, 1'b1);
    bus_xfer(1'b1, knock_pkg::OFS_LEVELS, 32'h03e8_1388);
    repeat (3) begin
      wait_fire(1);
      chk(32'(seen.level[0] >= 16'h0fa0 && seen.level[0] <= 16'h1770), 32'h1, "spread");
      moved += (seen.level[0] != 16'h1388) ? 1 : 0;
    end
    // A spread that is ignored would leave every level exactly at 5000
    chk(32'(moved > 0), 32'h1, "spread never moved the level");
    cfg(0, 10'h2bc, 8'hfb, 1'b0, 1'b0, 1'b0);
    wait_fire(1);
    chk(32'(seen.level[0] >= 16'h1f40 && seen.level[0] <= 16'h2710), 32'h1, "loud spread");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    rst       = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_angle();
    t_prob();
    t_seq();
    t_noise();
    tally_and_finish();
  end
endmodule // tb_top
